// ### rtl/mfs_pkg.sv
package mfs_pkg;
    localparam int          CLK_HZ         = 100_000_000;
    // Lock release interval and its cycle count
    localparam int          LOCK_OFF_MS    = 5000;
    localparam int          LOCK_OFF_CYC   = LOCK_OFF_MS * (CLK_HZ / 1000);
    // Output ramp step interval
    localparam int          RAMP_STEP_US   = 20;
    localparam int          RAMP_STEP_CYC  = RAMP_STEP_US * (CLK_HZ / 1_000_000);
    // Supply voltage sampling interval
    localparam int          VCC_SMP_US     = 10;
    localparam int          VCC_SMP_CYC    = VCC_SMP_US * (CLK_HZ / 1_000_000);
    // Serial target address, value is arbitrary
    localparam logic [6:0]  DEV_ADDR       = 7'h2a;

    localparam logic [7:0]  REG_SPD_HI     = 8'h01;
    localparam logic [7:0]  REG_SPD_LO     = 8'h02;
    localparam logic [7:0]  REG_PROT_STAT  = 8'h03;
    localparam logic [7:0]  REG_LOCK_STAT  = 8'h04;
    localparam logic [7:0]  REG_PH_CUR     = 8'h05;
    localparam logic [7:0]  REG_VCC_MEAS   = 8'h06;
    localparam logic [7:0]  REG_MODE_CFG   = 8'h2c;
    localparam logic [7:0]  REG_LOCK_CFG   = 8'h30;

    localparam int          ST_OC_BIT      = 0;
    localparam int          ST_OT_BIT      = 1;
    localparam int          ST_OV_BIT      = 2;
    localparam int          ST_UV_BIT      = 3;
    localparam int          ST_LOCK_BIT    = 5;
    localparam int          MODE_SLEEP_BIT = 2;
    localparam int          LOCK_THR_LSB   = 3;
    localparam logic [7:0]  LOCK_THR_STEP  = 8'h04;

    localparam logic [7:0]  CFG_RST        = 8'h00;

    typedef enum logic [1:0] {
        MFS_SRC_ANALOG,
        MFS_SRC_DUTY,
        MFS_SRC_FREQ,
        MFS_SRC_SERIAL
    } mfs_src_t;
endpackage

// ### rtl/mfs_supervisor.sv
`timescale 1ns/1ps
// Operation
// RULE1: Thermal trip disables drive until 140C recovery
// RULE2: Over-temperature flag at 0x03 bit 1
// RULE3: Under-voltage lockout 4.5V, release at 4.8V
// RULE4: Under-voltage flag at 0x03 bit 3
// RULE5: Over-voltage lockout 22V, release at 21.5V
// RULE6: Over-voltage flag at 0x03 bit 2
// RULE7: Over-current puts drivers high impedance
// RULE8: Over-current flag at 0x03 bit 0
// RULE9: Lock current limit from 0x30 bits 5:3
// RULE10: Stalled rotor stops drive immediately
// RULE11: Restart automatically after five second wait
// RULE12: Repeat stop-wait cycles while lock persists
// RULE13: Lock flag at 0x04 bit 5
// RULE14: Serial speed command in 0x01, 0x02
// RULE15: Speed from duty, frequency, analog or serial
// RULE16: Duty follows command, ramp and current clamp
// RULE17: Third harmonic, one phase clamped low
// RULE18: Speed indicator toggles with commutation
// RULE19: Fuse parameters loaded at reset, sleep exit
// RULE20: Host register writes override fuse values
// RULE21: Phase current and supply readable serially
// RULE22: Lock threshold 0.4A steps, 0.4 to 3.2A
// RULE23: 0x2c bit 2 picks standby or sleep; code sleeps only with a pin speed source, serial gives standby
// RULE24: Any protection forces outputs off, flags track
module mfs_supervisor #(
    parameter int         LOCK_OFF_CYCLES = mfs_pkg::LOCK_OFF_CYC,
    parameter int         WIN_BITS        = 16,
    parameter logic [6:0] I2C_ADDR        = mfs_pkg::DEV_ADDR
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       speed_pin,
    input  wire logic [7:0] speed_analog,
    input  wire logic       temp_above_trip,
    input  wire logic       temp_below_recover,
    input  wire logic       vcc_below_uv,
    input  wire logic       vcc_above_uv_release,
    input  wire logic       vcc_above_ov,
    input  wire logic       vcc_below_ov_release,
    input  wire logic       overcurrent_det,
    input  wire logic       rotor_stall_det,
    input  wire logic [7:0] phase_current,
    input  wire logic [7:0] vcc_level,
    input  wire logic [7:0] one_time_param_store_mode,
    input  wire logic [7:0] one_time_param_store_lock,
    output logic [2:0]      phase_high_on,
    output logic [2:0]      phase_low_on,
    output logic            commutation_freq_out,
    output logic            stall_current_limit_hit,
    output logic            standby_out,
    output logic            sleep_out
);
    generate
        if (LOCK_OFF_CYCLES < 2 || WIN_BITS < 9 || WIN_BITS > 24) begin : g_chk
            $error("mfs_supervisor: unsupported parameter value");
        end
    endgenerate

    // Pin synchronisers
    localparam int SW = 11;
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic          scl_d_r;
    logic          sda_d_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r    <= 11'h003;
            s2_r    <= 11'h003;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            s1_r    <= {rotor_stall_det, overcurrent_det, vcc_below_ov_release, vcc_above_ov,
                        vcc_above_uv_release, vcc_below_uv, temp_below_recover, temp_above_trip,
                        speed_pin, sda_in, scl_in};
            s2_r    <= s1_r;
            scl_d_r <= s2_r[0];
            sda_d_r <= s2_r[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic spd_s;
    logic stall_s;
    assign scl_s   = s2_r[0];
    assign sda_s   = s2_r[1];
    assign spd_s   = s2_r[2];
    assign stall_s = s2_r[10];

    // Protection states, a trip wins over a release
    logic ot_r;
    logic uv_r;
    logic ov_r;
    logic oc_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ot_r <= 1'b0;
            uv_r <= 1'b0;
            ov_r <= 1'b0;
            oc_r <= 1'b0;
        end else begin
            if (s2_r[3])
                ot_r <= 1'b1;                              // [RULE1]
            else if (s2_r[4])
                ot_r <= 1'b0;                              // [RULE1]
            if (s2_r[5])
                uv_r <= 1'b1;                              // [RULE3]
            else if (s2_r[6])
                uv_r <= 1'b0;                              // [RULE3]
            if (s2_r[7])
                ov_r <= 1'b1;                              // [RULE5]
            else if (s2_r[8])
                ov_r <= 1'b0;                              // [RULE5]
            oc_r <= s2_r[9];                               // [RULE7] [RULE8]
        end
    end

    // Registers
    logic [7:0] spd_hi_r;
    logic [7:0] spd_lo_r;
    logic [7:0] mode_cfg_r;
    logic [7:0] lock_cfg_r;
    logic [7:0] ph_cur_r;
    logic [7:0] vcc_r;
    logic       load_r;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       wake;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_r <= 1'b1;
        end else begin
            load_r <= wake;                                // [RULE19]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spd_hi_r   <= mfs_pkg::CFG_RST;
            spd_lo_r   <= mfs_pkg::CFG_RST;
            mode_cfg_r <= mfs_pkg::CFG_RST;
            lock_cfg_r <= mfs_pkg::CFG_RST;
        end else begin
            if (load_r) begin
                mode_cfg_r <= one_time_param_store_mode;   // [RULE19]
                lock_cfg_r <= one_time_param_store_lock;   // [RULE19]
            end
            if (wr_en) begin
                case (wr_addr)                             // [RULE20]
                    mfs_pkg::REG_SPD_HI:   spd_hi_r   <= wr_data; // [RULE14]
                    mfs_pkg::REG_SPD_LO:   spd_lo_r   <= wr_data; // [RULE14]
                    mfs_pkg::REG_MODE_CFG: mode_cfg_r <= wr_data;
                    mfs_pkg::REG_LOCK_CFG: lock_cfg_r <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    // Measurements: current every cycle, supply periodically
    logic [15:0] vcc_tmr_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_cur_r  <= 8'h00;
            vcc_r     <= 8'h00;
            vcc_tmr_r <= 16'h0000;
        end else begin
            ph_cur_r <= phase_current;                     // [RULE21]
            if (vcc_tmr_r == 16'(mfs_pkg::VCC_SMP_CYC - 1)) begin
                vcc_tmr_r <= 16'h0000;
                vcc_r     <= vcc_level;                    // [RULE21]
            end else begin
                vcc_tmr_r <= vcc_tmr_r + 16'h0001;
            end
        end
    end

    // Speed pin duty and frequency over a fixed window
    logic [WIN_BITS-1:0] win_r;
    logic [WIN_BITS-1:0] hi_cnt_r;
    logic [15:0]         edge_cnt_r;
    logic                spd_d_r;
    logic [7:0]          duty_meas_r;
    logic [7:0]          freq_meas_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_r       <= '0;
            hi_cnt_r    <= '0;
            edge_cnt_r  <= 16'h0000;
            spd_d_r     <= 1'b0;
            duty_meas_r <= 8'h00;
            freq_meas_r <= 8'h00;
        end else begin
            spd_d_r <= spd_s;
            win_r   <= win_r + 1'b1;
            if (&win_r) begin
                duty_meas_r <= hi_cnt_r[WIN_BITS-1 -: 8];  // [RULE15]
                freq_meas_r <= (|edge_cnt_r[15:8]) ? 8'hff : edge_cnt_r[7:0]; // [RULE15]
                hi_cnt_r    <= '0;
                edge_cnt_r  <= 16'h0000;
            end else begin
                if (spd_s)
                    hi_cnt_r <= hi_cnt_r + 1'b1;
                if (spd_s && !spd_d_r && !(&edge_cnt_r))
                    edge_cnt_r <= edge_cnt_r + 16'h0001;
            end
        end
    end

    mfs_pkg::mfs_src_t src;
    logic [15:0]       cmd;
    assign src = mfs_pkg::mfs_src_t'(mode_cfg_r[1:0]);
    always_comb begin
        case (src)                                         // [RULE15]
            mfs_pkg::MFS_SRC_ANALOG: cmd = {speed_analog, 8'h00};
            mfs_pkg::MFS_SRC_DUTY:   cmd = {duty_meas_r, 8'h00};
            mfs_pkg::MFS_SRC_FREQ:   cmd = {freq_meas_r, 8'h00};
            mfs_pkg::MFS_SRC_SERIAL: cmd = {spd_hi_r, spd_lo_r}; // [RULE14]
            default:                 cmd = 16'h0000;
        endcase
    end

    // Low power selection on zero command
    logic sleep_r;
    logic pin_src;
    logic zero_cmd;
    assign pin_src  = (src != mfs_pkg::MFS_SRC_SERIAL);
    assign zero_cmd = (cmd == 16'h0000);
    assign wake     = sleep_r && pin_src && !zero_cmd;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_r <= 1'b0;
        end else if (wake) begin
            sleep_r <= 1'b0;                               // [RULE19]
        end else if (zero_cmd && pin_src && mode_cfg_r[mfs_pkg::MODE_SLEEP_BIT]) begin
            sleep_r <= 1'b1;                               // [RULE23]
        end
    end
    assign sleep_out   = sleep_r;
    assign standby_out = zero_cmd && !sleep_r;             // [RULE23]

    // Lock current threshold, 0.1 A per current code
    logic [7:0] lock_thr;
    assign lock_thr = 8'({5'h00, lock_cfg_r[mfs_pkg::LOCK_THR_LSB +: 3]} + 8'h01)
                      * mfs_pkg::LOCK_THR_STEP;            // [RULE9] [RULE22]
    assign stall_current_limit_hit = (ph_cur_r >= lock_thr);

    // Rotor lock stop and timed restart
    typedef enum logic {MFS_LK_RUN, MFS_LK_HOLD} mfs_lock_t;
    mfs_lock_t   lk_r;
    logic [31:0] lk_cnt_r;
    logic        drive_en;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lk_r     <= MFS_LK_RUN;
            lk_cnt_r <= 32'h0000_0000;
        end else begin
            case (lk_r)
                MFS_LK_RUN: begin
                    lk_cnt_r <= 32'h0000_0000;
                    if (stall_s && drive_en)
                        lk_r <= MFS_LK_HOLD;               // [RULE10] [RULE12]
                end
                MFS_LK_HOLD: begin
                    lk_cnt_r <= lk_cnt_r + 32'h0000_0001;
                    if (lk_cnt_r == 32'(LOCK_OFF_CYCLES - 1))
                        lk_r <= MFS_LK_RUN;                // [RULE11]
                end
                default: lk_r <= MFS_LK_RUN;
            endcase
        end
    end

    logic fault;
    assign fault    = ot_r || uv_r || ov_r || oc_r || (lk_r == MFS_LK_HOLD); // [RULE24]
    assign drive_en = !sleep_r && !zero_cmd && !ot_r && !uv_r && !ov_r && !oc_r;

    // Output duty ramp, clamped by current limit
    logic [7:0]  duty_r;
    logic [15:0] ramp_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            duty_r <= 8'h00;
            ramp_r <= 16'h0000;
        end else if (fault || !drive_en) begin
            duty_r <= 8'h00;
            ramp_r <= 16'h0000;
        end else if (ramp_r == 16'(mfs_pkg::RAMP_STEP_CYC - 1)) begin
            ramp_r <= 16'h0000;
            if (duty_r > cmd[15:8])
                duty_r <= duty_r - 8'h01;                  // [RULE16]
            else if (duty_r < cmd[15:8] && !stall_current_limit_hit)
                duty_r <= duty_r + 8'h01;                  // [RULE16]
        end else begin
            ramp_r <= ramp_r + 16'h0001;
        end
    end

    // Electrical angle and carrier
    logic [15:0] ang_r;
    logic [7:0]  car_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ang_r <= 16'h0000;
            car_r <= 8'h00;
        end else begin
            car_r <= car_r + 8'h01;
            if (!fault && drive_en)
                ang_r <= ang_r + {8'h00, duty_r};
        end
    end
    assign commutation_freq_out = ang_r[15];               // [RULE18]

    // Triangle shapes minus their minimum give one clamped phase
    logic [7:0] shp [3];
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_shape
            logic [7:0] a;
            assign a      = ang_r[15:8] + 8'(p * 85);
            assign shp[p] = a[7] ? {~a[6:0], 1'b0} : {a[6:0], 1'b0};
        end
    endgenerate

    logic [7:0] mn;
    assign mn = (shp[0] < shp[1]) ? ((shp[0] < shp[2]) ? shp[0] : shp[2])
                                  : ((shp[1] < shp[2]) ? shp[1] : shp[2]); // [RULE17]

    logic [2:0] hi_nxt;
    logic [2:0] lo_nxt;
    generate
        for (p = 0; p < 3; p++) begin : g_pwm
            logic [15:0] lvl;
            assign lvl       = (shp[p] - mn) * duty_r;     // [RULE17]
            assign hi_nxt[p] = !fault && drive_en && (lvl[15:8] > car_r);
            assign lo_nxt[p] = !fault && drive_en && !(lvl[15:8] > car_r);
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_high_on <= 3'b000;
            phase_low_on  <= 3'b000;
        end else begin
            phase_high_on <= hi_nxt;                       // [RULE7] [RULE24]
            phase_low_on  <= lo_nxt;                       // [RULE7] [RULE24]
        end
    end

    // Serial register port
    typedef enum logic [3:0] {
        MFS_I_IDLE, MFS_I_ADDR, MFS_I_ACKA, MFS_I_PTR, MFS_I_ACKP,
        MFS_I_WDAT, MFS_I_ACKW, MFS_I_RDAT, MFS_I_RACK
    } mfs_i2c_t;
    mfs_i2c_t   ist_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic       rw_r;
    logic       nack_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_c  = scl_s && scl_d_r && !sda_s && sda_d_r;
    assign stop_c   = scl_s && scl_d_r && sda_s && !sda_d_r;

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        case (a)
            mfs_pkg::REG_SPD_HI:    rd_mux = spd_hi_r;
            mfs_pkg::REG_SPD_LO:    rd_mux = spd_lo_r;
            mfs_pkg::REG_PROT_STAT: rd_mux = {4'h0, uv_r, ov_r, ot_r, oc_r}; // [RULE2] [RULE4] [RULE6] [RULE8]
            mfs_pkg::REG_LOCK_STAT: rd_mux = 8'((lk_r == MFS_LK_HOLD) << mfs_pkg::ST_LOCK_BIT); // [RULE13]
            mfs_pkg::REG_PH_CUR:    rd_mux = ph_cur_r;     // [RULE21]
            mfs_pkg::REG_VCC_MEAS:  rd_mux = vcc_r;        // [RULE21]
            mfs_pkg::REG_MODE_CFG:  rd_mux = mode_cfg_r;
            mfs_pkg::REG_LOCK_CFG:  rd_mux = lock_cfg_r;
            default:                rd_mux = 8'h00;
        endcase
    endfunction

    assign wr_en   = scl_fall && (ist_r == MFS_I_WDAT) && (bit_r == 4'd8);
    assign wr_addr = ptr_r;
    assign wr_data = sh_r;
    assign sda_out = 1'b0;
    assign sda_oe  = (ist_r == MFS_I_ACKA) || (ist_r == MFS_I_ACKP) || (ist_r == MFS_I_ACKW)
                     || ((ist_r == MFS_I_RDAT) && !tx_r[7]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ist_r  <= MFS_I_IDLE;
            bit_r  <= 4'd0;
            sh_r   <= 8'h00;
            tx_r   <= 8'hff;
            ptr_r  <= 8'h00;
            rw_r   <= 1'b0;
            nack_r <= 1'b1;
        end else if (stop_c || sleep_r) begin
            ist_r <= MFS_I_IDLE;                           // [RULE23]
            tx_r  <= 8'hff;
        end else if (start_c) begin
            ist_r <= MFS_I_ADDR;
            bit_r <= 4'd0;
            tx_r  <= 8'hff;
        end else if (scl_rise) begin
            if (ist_r == MFS_I_ADDR || ist_r == MFS_I_PTR || ist_r == MFS_I_WDAT) begin
                sh_r  <= {sh_r[6:0], sda_s};
                bit_r <= bit_r + 4'd1;
            end else if (ist_r == MFS_I_RACK) begin
                nack_r <= sda_s;
            end
        end else if (scl_fall) begin
            case (ist_r)
                MFS_I_ADDR: if (bit_r == 4'd8) begin
                    rw_r  <= sh_r[0];
                    ist_r <= (sh_r[7:1] == I2C_ADDR) ? MFS_I_ACKA : MFS_I_IDLE;
                end
                MFS_I_ACKA: begin
                    bit_r <= 4'd0;
                    if (rw_r) begin
                        tx_r  <= rd_mux(ptr_r);
                        ist_r <= MFS_I_RDAT;
                    end else begin
                        ist_r <= MFS_I_PTR;
                    end
                end
                MFS_I_PTR: if (bit_r == 4'd8) begin
                    ptr_r <= sh_r;
                    ist_r <= MFS_I_ACKP;
                end
                MFS_I_ACKP, MFS_I_ACKW: begin
                    if (ist_r == MFS_I_ACKW)
                        ptr_r <= ptr_r + 8'h01;
                    bit_r <= 4'd0;
                    ist_r <= MFS_I_WDAT;
                end
                MFS_I_WDAT: if (bit_r == 4'd8)
                    ist_r <= MFS_I_ACKW;
                MFS_I_RDAT: begin
                    if (bit_r == 4'd7) begin
                        tx_r  <= 8'hff;
                        ist_r <= MFS_I_RACK;
                    end else begin
                        tx_r  <= {tx_r[6:0], 1'b1};
                        bit_r <= bit_r + 4'd1;
                    end
                end
                MFS_I_RACK: begin
                    if (nack_r) begin
                        ist_r <= MFS_I_IDLE;
                    end else begin
                        ptr_r <= ptr_r + 8'h01;
                        tx_r  <= rd_mux(ptr_r + 8'h01);
                        bit_r <= 4'd0;
                        ist_r <= MFS_I_RDAT;
                    end
                end
                default: ist_r <= MFS_I_IDLE;
            endcase
        end
    end
endmodule

// ### test/mfs_i2c_host.sv
`timescale 1ns/1ps
module mfs_i2c_host #(
    parameter int H = 8
) (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    int nak = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic bit_out(input logic b);
        sda_low = !b;
        tick(H);
        scl = 1'b1;
        tick(H);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        tick(H);
        scl = 1'b1;
        tick(H);
        b = sda_line;
        scl = 1'b0;
        tick(2);
    endtask
    task automatic start_c();
        sda_low = 1'b0;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_low = 1'b1;
        tick(H);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic stop_c();
        sda_low = 1'b1;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_low = 1'b0;
        tick(H);
    endtask
    task automatic send(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(a);
        nak += int'(a);
    endtask
    // Pointer then data, one stop per register write
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        start_c();
        send({mfs_pkg::DEV_ADDR, 1'b0});
        send(p);
        send(d);
        stop_c();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        start_c();
        send({mfs_pkg::DEV_ADDR, 1'b0});
        send(p);
        start_c();
        send({mfs_pkg::DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(1'b1);
        stop_c();
    endtask
endmodule

// ### test/mfs_supervisor_properties.sv
`timescale 1ns/1ps
module mfs_supervisor_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       sda_out,
    input wire logic       temp_above_trip,
    input wire logic       temp_below_recover,
    input wire logic       vcc_below_uv,
    input wire logic       vcc_above_uv_release,
    input wire logic       vcc_above_ov,
    input wire logic       vcc_below_ov_release,
    input wire logic       overcurrent_det,
    input wire logic       rotor_stall_det,
    input wire logic [2:0] phase_high_on,
    input wire logic [2:0] phase_low_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic gates_off = phase_high_on == 3'h0 && phase_low_on == 3'h0;

    a_ot_hyst_off: assert property (temp_above_trip ##1 (!temp_above_trip && !temp_below_recover) [*6] |-> gates_off)
        else $error("thermal trip released early");
    a_uv_hyst_off: assert property (vcc_below_uv ##1 (!vcc_below_uv && !vcc_above_uv_release) [*6] |-> gates_off)
        else $error("undervoltage lockout released early");
    a_ov_hyst_off: assert property (vcc_above_ov ##1 (!vcc_above_ov && !vcc_below_ov_release) [*6] |-> gates_off)
        else $error("overvoltage lockout released early");
    a_oc_hiz_hold: assert property (overcurrent_det [*6] |-> gates_off)
        else $error("drivers active during overcurrent");
    a_any_fault_off: assert property ((temp_above_trip || vcc_below_uv || vcc_above_ov) [*6] |-> gates_off)
        else $error("drivers active during fault");
    a_stall_stop_now: assert property ($rose(rotor_stall_det) |-> ##6 gates_off)
        else $error("drive not stopped on stall");
    a_phase_clamp_low: assert property (phase_high_on != 3'h0 |-> phase_low_on != 3'h0
        && (phase_high_on & phase_low_on) == 3'h0)
        else $error("no phase clamped low");
    a_sda_only_pull: assert property (sda_out == 1'b0)
        else $error("data line driven high");

    c_oc: cover property (overcurrent_det [*6]);
    c_stall: cover property ($rose(rotor_stall_det));
    c_drive: cover property (phase_high_on != 3'h0);
endmodule
bind mfs_supervisor mfs_supervisor_chk mfs_supervisor_chk_i (.clk, .rst, .sda_out, .temp_above_trip,
    .temp_below_recover, .vcc_below_uv, .vcc_above_uv_release, .vcc_above_ov, .vcc_below_ov_release,
    .overcurrent_det, .rotor_stall_det, .phase_high_on, .phase_low_on);

// ### test/mfs_supervisor_tb_top.sv
`timescale 1ns/1ps
module mfs_supervisor_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       scl_in, sda_in, sda_out, sda_oe, host_low;
    logic       speed_pin = 1'b0;
    logic [7:0] speed_analog, vcc_level, fuse_lock, v;
    logic [7:0] phase_current = 8'h00;
    logic [3:0] set_v = 4'h0;
    logic [3:0] rel_v = 4'hf;
    logic       rotor_stall_det = 1'b0;
    wire logic  temp_above_trip, temp_below_recover, vcc_below_uv, vcc_above_uv_release;
    wire logic  vcc_above_ov, vcc_below_ov_release, overcurrent_det;
    logic [2:0] phase_high_on, phase_low_on;
    logic       commutation_freq_out, stall_current_limit_hit, standby_out, sleep_out;
    int         num_errors = 0;
    int         cmp_count = 0;
    int         mdl [256];
    always #5 clk = ~clk;
    // Pulled-up open-drain data wire
    assign sda_in = !(sda_oe || host_low);
    assign {vcc_below_uv, vcc_above_ov, temp_above_trip, overcurrent_det} = set_v;
    assign {vcc_above_uv_release, vcc_below_ov_release, temp_below_recover} = rel_v[3:1];
    mfs_supervisor #(.LOCK_OFF_CYCLES(200), .WIN_BITS(9)) mfs_supervisor_i (.clk, .rst, .scl_in, .sda_in,
        .sda_out, .sda_oe, .speed_pin, .speed_analog, .temp_above_trip, .temp_below_recover, .vcc_below_uv,
        .vcc_above_uv_release, .vcc_above_ov, .vcc_below_ov_release, .overcurrent_det, .rotor_stall_det,
        .phase_current, .vcc_level, .one_time_param_store_mode(8'h03), .one_time_param_store_lock(fuse_lock),
        .phase_high_on, .phase_low_on, .commutation_freq_out, .stall_current_limit_hit, .standby_out,
        .sleep_out);
    mfs_i2c_host mfs_i2c_host_i (.clk, .sda_line(sda_in), .scl(scl_in), .sda_low(host_low));
    task automatic chk(input string n, input int e, input logic [7:0] g);
        cmp_count++;
        if (g !== e[7:0]) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e[7:0], g);
        end
    endtask
    task automatic rdc(input logic [7:0] a);
        logic [7:0] d;
        mfs_i2c_host_i.rd(a, d);
        chk($sformatf("reg %h", a), mdl[a], d);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        v = 8'($urandom(67));
        fuse_lock = 8'($urandom);
        speed_analog = 8'($urandom);
        vcc_level = 8'($urandom);
        wait_n(2);
        rst = 1'b0;
        mdl[8'h2c] = 3;
        mdl[8'h30] = fuse_lock;
        mdl[8'h06] = vcc_level;
        wait_n(4);
        chk("standby", 1, {7'h0, standby_out});
        rdc(8'h2c);
        rdc(8'h30);
        rdc(8'h7f);
        rdc(8'h06);
        v = 8'($urandom);
        mfs_i2c_host_i.wr(8'h30, v);
        mdl[8'h30] = v;
        rdc(8'h30);
        mfs_i2c_host_i.wr(8'h03, 8'hff);
        rdc(8'h03);
        phase_current = 8'((v[5:3] + 1) * 4);
        wait_n(4);
        chk("limit_hit", 1, {7'h0, stall_current_limit_hit});
        phase_current = phase_current - 8'h01;
        mdl[8'h05] = phase_current;
        wait_n(4);
        chk("limit_hit", 0, {7'h0, stall_current_limit_hit});
        rdc(8'h05);
        mdl[1] = int'(8'($urandom) | 8'h01);
        mdl[2] = int'(8'($urandom));
        mfs_i2c_host_i.wr(8'h01, mdl[1][7:0]);
        mfs_i2c_host_i.wr(8'h02, mdl[2][7:0]);
        rdc(8'h01);
        rdc(8'h02);
        chk("standby", 0, {7'h0, standby_out});
        wait_n(2100);
        for (int k = 0; k < 4; k++) begin
            rel_v[k] = 1'b0;
            set_v[k] = 1'b1;
            mdl[3] = 1 << k;
            wait_n(6);
            chk("gates", 0, {2'h0, phase_high_on, phase_low_on});
            rdc(8'h03);
            set_v[k] = 1'b0;
            if (k == 0) mdl[3] = 0;
            rdc(8'h03);
            rel_v[k] = 1'b1;
            mdl[3] = 0;
            wait_n(4);
            rdc(8'h03);
        end
        rotor_stall_det = 1'b1;
        mdl[4] = 8'h20;
        wait_n(6);
        chk("gates", 0, {2'h0, phase_high_on, phase_low_on});
        rdc(8'h04);
        wait_n(300);
        rdc(8'h04);
        rotor_stall_det = 1'b0;
        mdl[4] = 0;
        wait_n(300);
        rdc(8'h04);
        chk("missing acks", 0, 8'(mfs_i2c_host_i.nak));
        mfs_i2c_host_i.wr(8'h2c, 8'h05);
        chk("sleep", 1, {7'h0, sleep_out});
        speed_pin = 1'b1;
        wait_n(1100);
        chk("sleep", 0, {7'h0, sleep_out});
        rdc(8'h2c);
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule
